// ---- logic/cdpp_defines.svh ----
`ifndef CDPP_DEFINES_SVH
`define CDPP_DEFINES_SVH

// Register indexes; byte address is four times the index
`define CDPP_IDX_MODE1 10'h004
`define CDPP_IDX_MODE2 10'h005
`define CDPP_IDX_CC1 10'h006
`define CDPP_IDX_CC2 10'h007
`define CDPP_IDX_PROTECT 10'h00a
`define CDPP_IDX_DIVIDER 10'h00c
`define CDPP_IDX_CC3 10'h00d
`define CDPP_IDX_PM3 10'h013
`define CDPP_IDX_PLL1 10'h026
`define CDPP_IDX_PLL2 10'h027
`define CDPP_IDX_INV1 10'h3e0
`define CDPP_IDX_INV2 10'h3e1
`define CDPP_IDX_P9DIR 10'h3e2
`define CDPP_IDX_P3SEL 10'h3e3
`define CDPP_IDX_PRESCALE 10'h35f

// Field positions
`define CDPP_PR_CLK 0
`define CDPP_PR_MODE 1
`define CDPP_PR_PORT 2
`define CDPP_CC1_WDT 6
`define CDPP_CC2_STOP 0
`define CDPP_CC2_CPU1 7
`define CDPP_CC3_DET_EN 0
`define CDPP_CC3_CPU2 1
`define CDPP_CC3_FLAG 2
`define CDPP_PM3_CPU3 4
`define CDPP_PM3_CAN 5
`define CDPP_PLL2_DIV3 0

// PLL factor codes
`define CDPP_PLL_X6 3'h1
`define CDPP_PLL_X8 3'h2

// Reset values
`define CDPP_RST_BYTE 8'h00
`define CDPP_RST_WORD 32'h0000_0000

`endif

// ---- logic/cdpp_pkg.sv ----
package cdpp_pkg;

typedef logic [7:0] cdpp_byte_t;

typedef enum logic [1:0] {
	CDPP_IDLE,
	CDPP_WRITE,
	CDPP_RDWAIT,
	CDPP_RDDONE
} cdpp_phase_e;

endpackage

// ---- logic/cdpp_clock_ctrl.sv ----
`include "cdpp_defines.svh"

// Operation
// - Main divider: off, or divide by 2,3,4,6,8,10,12,14,16 via five bits
// - PLL: multiply by six then divide by two or three, or multiply by eight
// - Oscillator stop raises an interrupt, never a reset; no re-oscillation
// - Third clock control bit 0 enables stop detection; off means no report
// - Third clock control bit 2 flags a detected oscillator stop
// - No stop mode entry straight from low-speed or low-power mode
// - Programmable clock divides base by 2n, n 0 to 15, 0 undivided
// - Divide-by-32 clock only feeds the clock output pin, not timers
// - CPU clock source from three bits in three registers
// - Processor mode three bits 6-7 pick 2n source, bit 5 CAN clock
// - First clock control bit 6 is the watchdog function select
// - First PLL control bits 0-2 pick multiply by six or eight
// - Protect bit 0 opens clock, divider and PLL register writes
// - Protect bit 1 opens processor mode and inverter register writes
// - Protect bit 2 opens port nine direction and port three select writes
module cdpp_clock_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic osc_running,
	output logic osc_stop_irq,
	output logic stop_request,
	output logic [2:0] cpu_clk_sel,
	output logic watchdog_func_sel,
	output logic [3:0] pll_multiply,
	output logic [1:0] pll_divide,
	output logic main_clk_tick,
	output logic undivided_peripheral_clock,
	output logic divide_by_eight_clock,
	output logic programmable_even_divided_clock,
	output logic can_controller_clock,
	output logic clock_output_pin,
	output logic [7:0] port_nine_direction,
	output logic [7:0] port_three_function_select,
	output logic [7:0] inverter_control_first,
	output logic [7:0] inverter_control_second,
	output logic [7:0] processor_mode_first,
	output logic [7:0] processor_mode_second
);

	function automatic logic [4:0] divider_ratio(input logic [4:0] code);
		logic [4:0] r;
		r = 5'h01;
		case (code)
			5'h01: r = 5'h02;
			5'h02: r = 5'h03;
			5'h03: r = 5'h04;
			5'h04: r = 5'h06;
			5'h05: r = 5'h08;
			5'h06: r = 5'h0a;
			5'h07: r = 5'h0c;
			5'h08: r = 5'h0e;
			5'h09: r = 5'h10;
			default: r = 5'h01;
		endcase
		return r;
	endfunction

	function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
		return a == b;
	endfunction

	cdpp_pkg::cdpp_phase_e phase;
	cdpp_pkg::cdpp_phase_e next_phase;
	logic [9:0] idx;
	logic take;
	logic wr;
	logic [7:0] wbyte;

	cdpp_pkg::cdpp_byte_t write_protect_control;
	cdpp_pkg::cdpp_byte_t clock_control_first;
	cdpp_pkg::cdpp_byte_t clock_control_second;
	cdpp_pkg::cdpp_byte_t clock_control_third;
	cdpp_pkg::cdpp_byte_t main_clock_divider;
	cdpp_pkg::cdpp_byte_t pll_control_first;
	cdpp_pkg::cdpp_byte_t pll_control_second;
	cdpp_pkg::cdpp_byte_t processor_mode_third;
	cdpp_pkg::cdpp_byte_t count_source_prescaler;
	logic osc_flag;

	logic osc_meta;
	logic osc_sync;
	logic pr_clk;
	logic pr_mode;
	logic pr_port;
	logic low_speed;

	logic [4:0] main_cnt;
	logic [4:0] main_ratio;
	logic [2:0] div8_cnt;
	logic [4:0] div32_cnt;
	logic div32_tick;
	logic even_src;
	logic [4:0] even_cnt;
	logic [4:0] even_span;
	logic clock_output_pin_tick;

	// Bus front end: reads get one wait state so that a read right after a
	// write sees the freshly written value
	assign take = hsel & htrans[1] & hready;
	assign hresp = 1'b0;
	assign hreadyout = phase != cdpp_pkg::CDPP_RDWAIT;
	assign wr = phase == cdpp_pkg::CDPP_WRITE;
	assign wbyte = hwdata[7:0];

	always_comb begin
		next_phase = cdpp_pkg::CDPP_IDLE;
		case (phase)
			cdpp_pkg::CDPP_RDWAIT: next_phase = cdpp_pkg::CDPP_RDDONE;
			default: begin
				if (take) begin
					next_phase = hwrite ? cdpp_pkg::CDPP_WRITE :
						cdpp_pkg::CDPP_RDWAIT;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= cdpp_pkg::CDPP_IDLE;
		end else begin
			phase <= next_phase;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx <= 10'h000;
		end else if (take) begin
			idx <= haddr[11:2];
		end
	end

	assign pr_clk = write_protect_control[`CDPP_PR_CLK];
	assign pr_mode = write_protect_control[`CDPP_PR_MODE];
	assign pr_port = write_protect_control[`CDPP_PR_PORT];

	// The protect register itself is always writable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			write_protect_control <= `CDPP_RST_BYTE;
		end else if (wr && hit(idx, `CDPP_IDX_PROTECT)) begin
			write_protect_control <= {5'h00, wbyte[2:0]};
		end
	end

	// Clock group, open only while protect bit 0 is set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_control_first <= `CDPP_RST_BYTE;
			clock_control_second <= `CDPP_RST_BYTE;
			main_clock_divider <= `CDPP_RST_BYTE;
			pll_control_first <= `CDPP_RST_BYTE;
			pll_control_second <= `CDPP_RST_BYTE;
			clock_control_third <= `CDPP_RST_BYTE;
		end else if (wr && pr_clk) begin
			if (hit(idx, `CDPP_IDX_CC1)) begin
				clock_control_first <= wbyte;
			end
			if (hit(idx, `CDPP_IDX_CC2)) begin
				// Stop request bit is a strobe and never stored
				clock_control_second <= wbyte & 8'hfe;
			end
			if (hit(idx, `CDPP_IDX_DIVIDER)) begin
				main_clock_divider <= {3'h0, wbyte[4:0]};
			end
			if (hit(idx, `CDPP_IDX_PLL1)) begin
				pll_control_first <= {5'h00, wbyte[2:0]};
			end
			if (hit(idx, `CDPP_IDX_PLL2)) begin
				pll_control_second <= {7'h00, wbyte[0]};
			end
			if (hit(idx, `CDPP_IDX_CC3)) begin
				clock_control_third <= {6'h00, wbyte[1:0]};
			end
		end
	end

	// Oscillator sense pin is asynchronous to hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_meta <= 1'b1;
			osc_sync <= 1'b1;
		end else begin
			osc_meta <= osc_running;
			osc_sync <= osc_meta;
		end
	end

	// Sticky stop flag; a new detection beats a software clear in the same
	// cycle, and a restarted oscillator does not clear it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_flag <= 1'b0;
		end else if (clock_control_third[`CDPP_CC3_DET_EN] &&
			!osc_sync) begin
			osc_flag <= 1'b1;
		end else if (wr && pr_clk && hit(idx, `CDPP_IDX_CC3) &&
			!wbyte[`CDPP_CC3_FLAG]) begin
			osc_flag <= 1'b0;
		end
	end

	assign osc_stop_irq = osc_flag;

	// Processor mode and inverter group, open while protect bit 1 is set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			processor_mode_first <= `CDPP_RST_BYTE;
			processor_mode_second <= `CDPP_RST_BYTE;
			processor_mode_third <= `CDPP_RST_BYTE;
			inverter_control_first <= `CDPP_RST_BYTE;
			inverter_control_second <= `CDPP_RST_BYTE;
		end else if (wr && pr_mode) begin
			if (hit(idx, `CDPP_IDX_MODE1)) begin
				processor_mode_first <= wbyte;
			end
			if (hit(idx, `CDPP_IDX_MODE2)) begin
				processor_mode_second <= wbyte;
			end
			if (hit(idx, `CDPP_IDX_PM3)) begin
				processor_mode_third <= {wbyte[7:4], 4'h0};
			end
			if (hit(idx, `CDPP_IDX_INV1)) begin
				inverter_control_first <= wbyte;
			end
			if (hit(idx, `CDPP_IDX_INV2)) begin
				inverter_control_second <= wbyte;
			end
		end
	end

	// Port group, open while protect bit 2 is set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_nine_direction <= `CDPP_RST_BYTE;
			port_three_function_select <= `CDPP_RST_BYTE;
		end else if (wr && pr_port) begin
			if (hit(idx, `CDPP_IDX_P9DIR)) begin
				port_nine_direction <= wbyte;
			end
			if (hit(idx, `CDPP_IDX_P3SEL)) begin
				port_three_function_select <= wbyte;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_source_prescaler <= `CDPP_RST_BYTE;
		end else if (wr && hit(idx, `CDPP_IDX_PRESCALE)) begin
			count_source_prescaler <= {4'h0, wbyte[3:0]};
		end
	end

	// CPU clock source and mode controls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_clk_sel <= 3'h0;
			watchdog_func_sel <= 1'b0;
		end else begin
			cpu_clk_sel <= {processor_mode_third[`CDPP_PM3_CPU3],
				clock_control_third[`CDPP_CC3_CPU2],
				clock_control_second[`CDPP_CC2_CPU1]};
			watchdog_func_sel <=
				clock_control_first[`CDPP_CC1_WDT];
		end
	end

	// Any non-main CPU source counts as low-speed or low-power mode
	assign low_speed = cpu_clk_sel != 3'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_request <= 1'b0;
		end else begin
			stop_request <= wr && pr_clk && hit(idx, `CDPP_IDX_CC2) &&
				wbyte[`CDPP_CC2_STOP] && !low_speed;
		end
	end

	// PLL factor decode; an unused code keeps the PLL at multiply by eight
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_multiply <= 4'h8;
			pll_divide <= 2'h1;
		end else if (pll_control_first[2:0] == `CDPP_PLL_X6) begin
			pll_multiply <= 4'h6;
			pll_divide <= pll_control_second[`CDPP_PLL2_DIV3] ?
				2'h3 : 2'h2;
		end else begin
			pll_multiply <= 4'h8;
			pll_divide <= 2'h1;
		end
	end

	// Main divider; a ratio change applies at once to the running count
	assign main_ratio = divider_ratio(main_clock_divider[4:0]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			main_cnt <= 5'h00;
			main_clk_tick <= 1'b0;
		end else if (main_cnt >= main_ratio - 5'h01) begin
			main_cnt <= 5'h00;
			main_clk_tick <= 1'b1;
		end else begin
			main_cnt <= main_cnt + 5'h01;
			main_clk_tick <= 1'b0;
		end
	end

	// Fixed peripheral ticks follow the main divider
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div8_cnt <= 3'h0;
			div32_cnt <= 5'h00;
		end else if (main_clk_tick) begin
			div8_cnt <= div8_cnt + 3'h1;
			div32_cnt <= div32_cnt + 5'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			undivided_peripheral_clock <= 1'b0;
			divide_by_eight_clock <= 1'b0;
			div32_tick <= 1'b0;
		end else begin
			undivided_peripheral_clock <= main_clk_tick;
			divide_by_eight_clock <= main_clk_tick && div8_cnt == 3'h7;
			div32_tick <= main_clk_tick && div32_cnt == 5'h1f;
		end
	end

	// Programmable 2n divider; its source is picked by bits 6-7
	always_comb begin
		case (processor_mode_third[7:6])
			2'h1: even_src = main_clk_tick;
			2'h2: even_src = divide_by_eight_clock;
			default: even_src = 1'b1;
		endcase
	end

	assign even_span = {count_source_prescaler[3:0], 1'b0};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			even_cnt <= 5'h00;
			programmable_even_divided_clock <= 1'b0;
		end else if (!even_src) begin
			programmable_even_divided_clock <= 1'b0;
		end else if (even_span == 5'h00) begin
			programmable_even_divided_clock <= 1'b1;
		end else if (even_cnt >= even_span - 5'h01) begin
			even_cnt <= 5'h00;
			programmable_even_divided_clock <= 1'b1;
		end else begin
			even_cnt <= even_cnt + 5'h01;
			programmable_even_divided_clock <= 1'b0;
		end
	end

	// CAN clock: bit 5 picks undivided base or the main divided tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			can_controller_clock <= 1'b0;
		end else begin
			can_controller_clock <= processor_mode_third[`CDPP_PM3_CAN] ?
				1'b1 : main_clk_tick;
		end
	end

	// Clock output pin; the divide-by-32 tick goes here only, never to
	// a timer source
	always_comb begin
		case (clock_control_first[1:0])
			2'h1: clock_output_pin_tick = divide_by_eight_clock;
			2'h2: clock_output_pin_tick = div32_tick;
			2'h3: clock_output_pin_tick = programmable_even_divided_clock;
			default: clock_output_pin_tick = 1'b0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_output_pin <= 1'b0;
		end else if (clock_control_first[1:0] == 2'h0) begin
			clock_output_pin <= 1'b0;
		end else if (clock_output_pin_tick) begin
			clock_output_pin <= !clock_output_pin;
		end
	end

	// Read data is loaded during the wait state and held until next read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= `CDPP_RST_WORD;
		end else if (phase == cdpp_pkg::CDPP_RDWAIT) begin
			case (idx)
				`CDPP_IDX_MODE1: hrdata <= {24'h00_0000, processor_mode_first};
				`CDPP_IDX_MODE2: hrdata <= {24'h00_0000,
					processor_mode_second};
				`CDPP_IDX_CC1: hrdata <= {24'h00_0000, clock_control_first};
				`CDPP_IDX_CC2: hrdata <= {24'h00_0000, clock_control_second};
				`CDPP_IDX_PROTECT: hrdata <= {24'h00_0000,
					write_protect_control};
				`CDPP_IDX_DIVIDER: hrdata <= {24'h00_0000, main_clock_divider};
				`CDPP_IDX_CC3: hrdata <= {24'h00_0000,
					clock_control_third[7:3], osc_flag,
					clock_control_third[1:0]};
				`CDPP_IDX_PM3: hrdata <= {24'h00_0000, processor_mode_third};
				`CDPP_IDX_PLL1: hrdata <= {24'h00_0000, pll_control_first};
				`CDPP_IDX_PLL2: hrdata <= {24'h00_0000, pll_control_second};
				`CDPP_IDX_INV1: hrdata <= {24'h00_0000,
					inverter_control_first};
				`CDPP_IDX_INV2: hrdata <= {24'h00_0000,
					inverter_control_second};
				`CDPP_IDX_P9DIR: hrdata <= {24'h00_0000, port_nine_direction};
				`CDPP_IDX_P3SEL: hrdata <= {24'h00_0000,
					port_three_function_select};
				`CDPP_IDX_PRESCALE: hrdata <= {24'h00_0000,
					count_source_prescaler};
				default: hrdata <= `CDPP_RST_WORD;
			endcase
		end
	end

endmodule

// ---- dv/cdpp_monitor.sv ----
module cdpp_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic osc_running,
	input wire logic osc_stop_irq,
	input wire logic stop_request,
	input wire logic [2:0] cpu_clk_sel,
	input wire logic watchdog_func_sel,
	input wire logic [3:0] pll_multiply,
	input wire logic [1:0] pll_divide,
	input wire logic [7:0] port_nine_direction,
	input wire logic [7:0] inverter_control_first
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr_acc;
	// Register outputs may carry one extra stage, so allow two or three edges
	assign wr_acc = hsel & htrans[1] & hwrite & hready;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_irq_after_stop: assert property (
		$rose(osc_stop_irq) |-> !$past(osc_running, 2) || !$past(osc_running, 3))
		else $error("stop flag rose without a stopped oscillator");
	a_irq_no_autoclear: assert property (
		$fell(osc_stop_irq) |-> $past(wr_acc, 2) || $past(wr_acc, 3))
		else $error("stop flag cleared without a register write");
	a_stop_gated: assert property (
		stop_request |-> cpu_clk_sel == 3'h0)
		else $error("stop request while a slow clock mode is selected");
	a_stop_one_cycle: assert property (
		stop_request |=> !stop_request)
		else $error("stop request longer than one cycle");
	a_stop_cause: assert property (
		stop_request |-> $past(wr_acc, 2) || $past(wr_acc, 3))
		else $error("stop request without a register write");
	a_pll_legal: assert property (
		(pll_multiply == 4'h8 && pll_divide == 2'h1) ||
		(pll_multiply == 4'h6 && pll_divide inside {2'h2, 2'h3}))
		else $error("illegal multiplier and divider pair");
	a_cpu_sel_hold: assert property (
		$changed(cpu_clk_sel) |-> $past(wr_acc, 2) || $past(wr_acc, 3))
		else $error("cpu clock select changed without a write");
	a_wdt_sel_hold: assert property (
		$changed(watchdog_func_sel) |-> $past(wr_acc, 2) || $past(wr_acc, 3))
		else $error("watchdog select changed without a write");
	a_port_dir_hold: assert property (
		$changed(port_nine_direction) |-> $past(wr_acc, 2) || $past(wr_acc, 3))
		else $error("port direction changed without a write");
	a_inv_ctrl_hold: assert property (
		$changed(inverter_control_first) |->
		$past(wr_acc, 2) || $past(wr_acc, 3))
		else $error("inverter control changed without a write");
	cover property (stop_request);
	cover property ($rose(osc_stop_irq));
	cover property (hsel && htrans[1] && !hwrite && hready ##2 hreadyout);
endmodule

// ---- dv/clock_divider_pll_protect_test.sv ----
`include "cdpp_defines.svh"

module clock_divider_pll_protect_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic osc_running = 1'h1;
	logic rd_phase = 1'h0;
	logic pin_d = 1'h0;
	logic hreadyout, hresp, osc_stop_irq, stop_request, watchdog_func_sel;
	logic main_clk_tick, undivided_peripheral_clock, divide_by_eight_clock;
	logic programmable_even_divided_clock, can_controller_clock;
	logic clock_output_pin;
	logic [31:0] hrdata;
	logic [2:0] cpu_clk_sel;
	logic [3:0] pll_multiply;
	logic [1:0] pll_divide;
	logic [7:0] port_nine_direction, port_three_function_select;
	logic [7:0] inverter_control_first, inverter_control_second;
	logic [7:0] processor_mode_first, processor_mode_second;
	int miscompares = 0;
	int checked = 0;
	int seed = 81175;
	int stops = 0;
	logic [31:0] exp_q[$];
	logic [9:0] ti[13] = '{`CDPP_IDX_CC1, `CDPP_IDX_CC2, `CDPP_IDX_CC3,
		`CDPP_IDX_DIVIDER, `CDPP_IDX_PLL1, `CDPP_IDX_PLL2, `CDPP_IDX_MODE1,
		`CDPP_IDX_MODE2, `CDPP_IDX_PM3, `CDPP_IDX_INV1, `CDPP_IDX_INV2,
		`CDPP_IDX_P9DIR, `CDPP_IDX_P3SEL};
	int tb[13] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 2, 2};
	logic [7:0] tv[13] = '{8'h40, 8'h80, 8'h02, 8'h03, 8'h01, 8'h01, 8'h00,
		8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
	int rat[11] = '{1, 2, 3, 4, 6, 8, 10, 12, 14, 16, 1};

	cdpp_clock_ctrl i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .osc_running(osc_running),
		.osc_stop_irq(osc_stop_irq), .stop_request(stop_request),
		.cpu_clk_sel(cpu_clk_sel), .watchdog_func_sel(watchdog_func_sel),
		.pll_multiply(pll_multiply), .pll_divide(pll_divide),
		.main_clk_tick(main_clk_tick),
		.undivided_peripheral_clock(undivided_peripheral_clock),
		.divide_by_eight_clock(divide_by_eight_clock),
		.programmable_even_divided_clock(programmable_even_divided_clock),
		.can_controller_clock(can_controller_clock),
		.clock_output_pin(clock_output_pin),
		.port_nine_direction(port_nine_direction),
		.port_three_function_select(port_three_function_select),
		.inverter_control_first(inverter_control_first),
		.inverter_control_second(inverter_control_second),
		.processor_mode_first(processor_mode_first),
		.processor_mode_second(processor_mode_second)
	);

	always #4 hclk = ~hclk;

	always @(posedge hclk) begin
		pin_d <= clock_output_pin;
		if (stop_request === 1'h1)
			stops <= stops + 1;
	end

	// Read data is judged only at the edge that ends the data phase
	always @(posedge hclk)
		if (rd_phase && hreadyout === 1'h1)
			check(hrdata, exp_q.pop_front());

	function automatic void check(logic [31:0] a, logic [31:0] e);
		checked++;
		if (a !== e) begin
			miscompares++;
			$display("MISMATCH %0t got %h want %h", $time, a, e);
		end
	endfunction

	task automatic results();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic timeout_hit();
		miscompares++;
		$display("MISMATCH %0t wait ran out", $time);
		results();
	endtask

	task automatic bus(logic wr, logic [9:0] idx, logic [7:0] d);
		int n;
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {20'h0_0000, idx, 2'h0};
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'h1 && n < 50);
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		rd_phase <= ~wr;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'h1 && n < 50);
		rd_phase <= 1'h0;
		if (n >= 50)
			timeout_hit();
	endtask

	task automatic wr(logic [9:0] idx, logic [7:0] d);
		bus(1'h1, idx, d);
	endtask

	task automatic rd(logic [9:0] idx, logic [7:0] e);
		exp_q.push_back({24'h00_0000, e});
		bus(1'h0, idx, 8'h00);
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge hclk);
	endtask

	function automatic logic tk(int s);
		case (s)
			0: return main_clk_tick;
			1: return programmable_even_divided_clock;
			2: return divide_by_eight_clock;
			3: return undivided_peripheral_clock;
			4: return can_controller_clock;
			default: return clock_output_pin ^ pin_d;
		endcase
	endfunction

	// One period is skipped first: a new ratio may land mid-count
	task automatic per(int s, int e);
		int n, c;
		n = 0;
		c = 0;
		repeat (2) do begin
			@(posedge hclk);
			n++;
		end while (tk(s) !== 1'h1 && n < 400);
		do begin
			@(posedge hclk);
			c++;
		end while (tk(s) !== 1'h1 && c < 400);
		if (n >= 400)
			timeout_hit();
		check(c, e);
	endtask

	task automatic pll(logic [7:0] a, logic [7:0] b, int m, int d);
		wr(`CDPP_IDX_PLL1, a);
		wr(`CDPP_IDX_PLL2, b);
		cyc(3);
		check(pll_multiply, m);
		check(pll_divide, d);
	endtask

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		for (int i = 0; i < 13; i++) begin
			if (tv[i] == 8'h00)
				tv[i] = 8'($random(seed)) | 8'h01;
			wr(`CDPP_IDX_PROTECT, 8'h00);
			wr(ti[i], tv[i]);
			rd(ti[i], 8'h00);
			wr(`CDPP_IDX_PROTECT, 8'h01 << tb[i]);
			wr(ti[i], tv[i]);
			rd(ti[i], tv[i]);
		end
		rd(`CDPP_IDX_PROTECT, 8'h04);
		wr(10'h3ff, 8'h5a);
		rd(10'h3ff, 8'h00);
		check(cpu_clk_sel, 3'h3);
		check(watchdog_func_sel, 1'h1);
		check(can_controller_clock, 1'h1);
		check(processor_mode_first, tv[6]);
		check(processor_mode_second, tv[7]);
		check(inverter_control_first, tv[9]);
		check(inverter_control_second, tv[10]);
		check(port_nine_direction, tv[11]);
		check(port_three_function_select, tv[12]);
		check(hresp, 1'h0);
		$display("test protect done");
		wr(`CDPP_IDX_PROTECT, 8'h03);
		wr(`CDPP_IDX_PM3, 8'h10);
		cyc(3);
		check(cpu_clk_sel, 3'h7);
		wr(`CDPP_IDX_CC2, 8'h81);
		cyc(4);
		check(stops, 0);
		wr(`CDPP_IDX_CC2, 8'h00);
		wr(`CDPP_IDX_CC3, 8'h00);
		wr(`CDPP_IDX_PM3, 8'h00);
		cyc(3);
		check(cpu_clk_sel, 3'h0);
		wr(`CDPP_IDX_CC2, 8'h01);
		cyc(4);
		check(stops, 1);
		$display("test stop done");
		pll(8'h01, 8'h00, 6, 2);
		pll(8'h01, 8'h01, 6, 3);
		pll(8'h02, 8'h00, 8, 1);
		for (int c = 0; c < 11; c++) begin
			wr(`CDPP_IDX_DIVIDER, c[7:0]);
			per(0, rat[c]);
			per(3, rat[c]);
			per(4, rat[c]);
		end
		wr(`CDPP_IDX_DIVIDER, 8'h00);
		foreach (rat[k]) begin
			if (k < 4) begin
				wr(`CDPP_IDX_PRESCALE, (k == 3) ? 8'h0f : k[7:0]);
				per(1, (k == 0) ? 1 : ((k == 3) ? 30 : 2 * k));
			end
		end
		wr(`CDPP_IDX_PRESCALE, 8'h01);
		wr(`CDPP_IDX_PM3, 8'h80);
		per(1, 16);
		per(2, 8);
		wr(`CDPP_IDX_CC1, 8'h02);
		per(5, 32);
		wr(`CDPP_IDX_CC1, 8'h00);
		cyc(3);
		check(clock_output_pin, 1'h0);
		$display("test clocks done");
		osc_running <= 1'h0;
		cyc(8);
		check(osc_stop_irq, 1'h0);
		rd(`CDPP_IDX_CC3, 8'h00);
		wr(`CDPP_IDX_CC3, 8'h01);
		cyc(6);
		check(osc_stop_irq, 1'h1);
		rd(`CDPP_IDX_CC3, 8'h05);
		osc_running <= 1'h1;
		cyc(8);
		check(osc_stop_irq, 1'h1);
		wr(`CDPP_IDX_CC3, 8'h00);
		rd(`CDPP_IDX_CC3, 8'h00);
		$display("test oscillator done");
		results();
	end
endmodule

bind cdpp_clock_ctrl cdpp_monitor i_mon (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.osc_running(osc_running), .osc_stop_irq(osc_stop_irq),
	.stop_request(stop_request), .cpu_clk_sel(cpu_clk_sel),
	.watchdog_func_sel(watchdog_func_sel), .pll_multiply(pll_multiply),
	.pll_divide(pll_divide), .port_nine_direction(port_nine_direction),
	.inverter_control_first(inverter_control_first)
);
